// [inc/fsmap_pkg.sv]
package fsmap_pkg;
  // --------------------------------------------------------------
  // Geometry
  // --------------------------------------------------------------
  localparam int ADDR_W = 25;
  localparam int DATA_W = 16;
  localparam int SEC_SHIFT = 17;
  localparam int SEC_W = 8;
  localparam int OFF_W = 17;
  localparam logic [7:0] MAX_SEC_LARGE = 8'hFF;
  localparam logic [7:0] MAX_SEC_MID = 8'h7F;
  localparam logic [7:0] MAX_SEC_SMALL = 8'h3F;
  localparam int PSEC_IDX_LO = 11;
  localparam int PSEC_SEL_LO = 14;
  localparam int PSEC_SEL_HI = 16;
  localparam logic [2:0] PSEC_SEL_BOTTOM = 3'h0;
  localparam logic [2:0] PSEC_SEL_TOP = 3'h7;
  // --------------------------------------------------------------
  // Overlay layout
  // --------------------------------------------------------------
  localparam int TBL_W = 7;
  localparam logic [16:0] ID_LAST = 17'h0000F;
  localparam logic [16:0] CFI_LAST = 17'h00079;
  localparam logic [15:0] UNDEF_WORD_DEF = 16'hFFFF;
  // --------------------------------------------------------------
  // Command words
  // --------------------------------------------------------------
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2AA;
  localparam logic [11:0] ID_ENTER_ADDR = 12'h555;
  localparam logic [11:0] CFI_ENTER_ADDR = 12'h055;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] ID_ENTER_DATA = 8'h90;
  localparam logic [7:0] CFI_ENTER_DATA = 8'h98;
  localparam logic [7:0] EXIT_DATA = 8'hF0;
  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    U_IDLE = 2'b00,
    U_FIRST = 2'b01,
    U_SECOND = 2'b10
  } unlock_e;
  typedef enum logic [1:0] {
    SRC_ARRAY = 2'b00,
    SRC_ID = 2'b01,
    SRC_CFI = 2'b10,
    SRC_UNDEF = 2'b11
  } rd_src_e;
endpackage

// [rtl/flash_sector_map.sv]
`timescale 1ns/1ps
// Overview of operation
// RL1 - Main array is split into aligned sectors of 0x20000 words each.
// RL2 - Highest sector index is 255, 127 or 63 depending on density.
// RL3 - Optionally the lowest or highest sector holds eight 4 kB parameter sectors.
// RL4 - Bottom or top placement comes from the non-volatile configuration setting.
// RL5 - Parameter sectors take the normal erase and program sequences by address.
// RL6 - Host supplies address down to bit 11; bits 16..11 select the parameter sector.
// RL7 - Bottom: sector n at n*0x800; words 0x4000..0x1FFFF stay sector zero.
// RL8 - Top: parameter sectors fill the last 0x4000 words of the highest sector.
// RL9 - Either identification or query entry brings up the same combined overlay.
// RL10 - Overlay replaces the addressed sector only; other sectors read undefined.
// RL11 - Offsets 0..0xF identification, 0x10..0x79 query, above that undefined.
// RL12 - Identification part exposes up to sixteen words of codes and status.
// RL13 - Query bytes sit in the low byte; high byte reads zero.
// RL14 - Identification words may use both bytes for added fields.
// RL15 - Exit command returns the address space to the main array.
// RL16 - Every write goes to the command buffer, never straight to storage.
// RL17 - Undefined overlay reads still drive a data word.
// RL18 - Writes never alter the table contents; only command sequences act.
module flash_sector_map #(
  parameter logic [7:0] MAX_SECTOR = fsmap_pkg::MAX_SEC_LARGE,
  parameter logic [15:0] UNDEF_WORD = fsmap_pkg::UNDEF_WORD_DEF
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Host transaction link, asynchronous to CLK_SYS
  input wire logic LINK_CK,
  input wire logic LINK_CS_N,
  input wire logic LINK_WR,
  input wire logic [fsmap_pkg::ADDR_W-1:0] LINK_ADDR,
  input wire logic [fsmap_pkg::DATA_W-1:0] LINK_WDATA,
  // Non-volatile configuration settings
  input wire logic PARAM_EN,
  input wire logic PARAM_TOP,
  // Main array read port, data taken in the same cycle as the strobe
  output logic ARRAY_RD,
  output logic [fsmap_pkg::ADDR_W-1:0] ARRAY_ADDR,
  input wire logic [fsmap_pkg::DATA_W-1:0] ARRAY_RDATA,
  // Overlay table read port, data taken in the same cycle as the strobe
  output logic TBL_RD,
  output logic [fsmap_pkg::TBL_W-1:0] TBL_IDX,
  input wire logic [fsmap_pkg::DATA_W-1:0] TBL_DATA,
  // Read answer
  output logic RD_VALID,
  output logic [fsmap_pkg::DATA_W-1:0] RD_DATA,
  // Command buffer
  output logic CMD_VALID,
  output logic [fsmap_pkg::ADDR_W-1:0] CMD_ADDR,
  output logic [fsmap_pkg::DATA_W-1:0] CMD_DATA,
  output logic [fsmap_pkg::SEC_W-1:0] CMD_SECTOR,
  output logic CMD_PSEC_HIT,
  output logic [2:0] CMD_PSEC_IDX,
  // Overlay status
  output logic OVL_ACTIVE,
  output logic [fsmap_pkg::SEC_W-1:0] OVL_SECTOR
);
  import fsmap_pkg::*;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic ck_1;
    logic ck_2;
    logic ck_3;
    logic cs_1;
    logic cs_2;
    logic wr_1;
    logic wr_2;
    logic [ADDR_W-1:0] addr_1;
    logic [ADDR_W-1:0] addr_2;
    logic [DATA_W-1:0] wd_1;
    logic [DATA_W-1:0] wd_2;
    logic taken;
    unlock_e unlock;
    logic rd_pend;
    rd_src_e rd_src;
    logic array_rd;
    logic [ADDR_W-1:0] array_addr;
    logic tbl_rd;
    logic [TBL_W-1:0] tbl_idx;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic cmd_valid;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_data;
    logic [SEC_W-1:0] cmd_sector;
    logic cmd_psec_hit;
    logic [2:0] cmd_psec_idx;
    logic ovl;
    logic [SEC_W-1:0] ovl_sector;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // --------------------------------------------------------------
  // Address decoding helpers
  // --------------------------------------------------------------
  // Upper bits beyond the density wrap, as the array has no cells there
  function automatic logic [SEC_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    sector_of = a[ADDR_W-1:SEC_SHIFT] & MAX_SECTOR; // RL1 RL2
  endfunction

  // Parameter sector hit: bits 16..14 pick the region, 13..11 the sector
  function automatic logic psec_hit(input logic [ADDR_W-1:0] a, input logic en,
                                    input logic top);
    logic [SEC_W-1:0] sec;
    sec = sector_of(a);
    if (!en) begin
      psec_hit = 1'b0;
    end else if (top) begin
      psec_hit = (sec == MAX_SECTOR) &&
                 (a[PSEC_SEL_HI:PSEC_SEL_LO] == PSEC_SEL_TOP); // RL8
    end else begin
      psec_hit = (sec == 8'h00) &&
                 (a[PSEC_SEL_HI:PSEC_SEL_LO] == PSEC_SEL_BOTTOM); // RL7
    end
  endfunction

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    logic [SEC_W-1:0] sec;
    logic [OFF_W-1:0] off;
    logic [7:0] wbyte;
    logic [11:0] low;
    s_nxt = s_r;
    sec = sector_of(s_r.addr_2);
    off = s_r.addr_2[OFF_W-1:0];
    wbyte = s_r.wd_2[7:0];
    low = s_r.addr_2[11:0];
    // Two-stage sampling of every link pin before use
    s_nxt.ck_1 = LINK_CK;
    s_nxt.ck_2 = s_r.ck_1;
    s_nxt.ck_3 = s_r.ck_2;
    s_nxt.cs_1 = LINK_CS_N;
    s_nxt.cs_2 = s_r.cs_1;
    s_nxt.wr_1 = LINK_WR;
    s_nxt.wr_2 = s_r.wr_1;
    s_nxt.addr_1 = LINK_ADDR;
    s_nxt.addr_2 = s_r.addr_1;
    s_nxt.wd_1 = LINK_WDATA;
    s_nxt.wd_2 = s_r.wd_1;
    // Strobes last one cycle
    s_nxt.array_rd = 1'b0;
    s_nxt.tbl_rd = 1'b0;
    s_nxt.rd_valid = 1'b0;
    s_nxt.cmd_valid = 1'b0;
    s_nxt.rd_pend = 1'b0;
    // Answer one cycle after the storage strobe
    if (s_r.rd_pend) begin
      s_nxt.rd_valid = 1'b1;
      unique case (s_r.rd_src)
        SRC_ARRAY: s_nxt.rd_data = ARRAY_RDATA;
        SRC_ID: s_nxt.rd_data = TBL_DATA; // RL12 RL14
        SRC_CFI: s_nxt.rd_data = {8'h00, TBL_DATA[7:0]}; // RL13
        SRC_UNDEF: s_nxt.rd_data = UNDEF_WORD; // RL17
      endcase
    end
    // One transaction per chip-select frame
    if (s_r.cs_2) begin
      s_nxt.taken = 1'b0;
    end else if (s_r.ck_2 && !s_r.ck_3 && !s_r.taken) begin
      s_nxt.taken = 1'b1;
      if (s_r.wr_2) begin
        // Writes only ever reach the command buffer; tables have no write path
        s_nxt.cmd_valid = 1'b1; // RL16 RL18
        s_nxt.cmd_addr = s_r.addr_2;
        s_nxt.cmd_data = s_r.wd_2;
        s_nxt.cmd_sector = sec;
        s_nxt.cmd_psec_hit = psec_hit(s_r.addr_2, PARAM_EN, PARAM_TOP); // RL3 RL4 RL5
        s_nxt.cmd_psec_idx = s_r.addr_2[PSEC_IDX_LO+2:PSEC_IDX_LO]; // RL6
        // Overlay entry and exit recogniser
        if (s_r.ovl) begin
          s_nxt.unlock = U_IDLE;
          if (wbyte == EXIT_DATA) begin
            s_nxt.ovl = 1'b0; // RL15
          end
        end else if (low == CFI_ENTER_ADDR && wbyte == CFI_ENTER_DATA) begin
          s_nxt.ovl = 1'b1; // RL9
          s_nxt.ovl_sector = sec;
          s_nxt.unlock = U_IDLE;
        end else begin
          unique case (s_r.unlock)
            U_IDLE: begin
              s_nxt.unlock = (low == UNLOCK1_ADDR && wbyte == UNLOCK1_DATA) ? U_FIRST : U_IDLE;
            end
            U_FIRST: begin
              s_nxt.unlock = (low == UNLOCK2_ADDR && wbyte == UNLOCK2_DATA) ? U_SECOND : U_IDLE;
            end
            U_SECOND: begin
              s_nxt.unlock = U_IDLE;
              if (low == ID_ENTER_ADDR && wbyte == ID_ENTER_DATA) begin
                s_nxt.ovl = 1'b1; // RL9
                s_nxt.ovl_sector = sec;
              end
            end
            default: s_nxt.unlock = U_IDLE;
          endcase
        end
      end else begin
        s_nxt.rd_pend = 1'b1;
        if (s_r.ovl && sec == s_r.ovl_sector) begin
          // Overlay starts at word zero of the entered sector
          s_nxt.tbl_idx = off[TBL_W-1:0];
          if (off <= ID_LAST) begin
            s_nxt.rd_src = SRC_ID; // RL11
            s_nxt.tbl_rd = 1'b1;
          end else if (off <= CFI_LAST) begin
            s_nxt.rd_src = SRC_CFI; // RL11
            s_nxt.tbl_rd = 1'b1;
          end else begin
            s_nxt.rd_src = SRC_UNDEF; // RL11
          end
        end else if (s_r.ovl) begin
          s_nxt.rd_src = SRC_UNDEF; // RL10
        end else begin
          s_nxt.rd_src = SRC_ARRAY;
          s_nxt.array_rd = 1'b1;
          s_nxt.array_addr = s_r.addr_2;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  // Sync stages reset too, so a stray edge right after reset is not seen
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_r <= '0;
      s_r.ck_1 <= 1'b0;
      s_r.cs_1 <= 1'b1;
      s_r.cs_2 <= 1'b1;
      s_r.unlock <= U_IDLE;
      s_r.rd_src <= SRC_ARRAY;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign ARRAY_RD = s_r.array_rd;
  assign ARRAY_ADDR = s_r.array_addr;
  assign TBL_RD = s_r.tbl_rd;
  assign TBL_IDX = s_r.tbl_idx;
  assign RD_VALID = s_r.rd_valid;
  assign RD_DATA = s_r.rd_data;
  assign CMD_VALID = s_r.cmd_valid;
  assign CMD_ADDR = s_r.cmd_addr;
  assign CMD_DATA = s_r.cmd_data;
  assign CMD_SECTOR = s_r.cmd_sector;
  assign CMD_PSEC_HIT = s_r.cmd_psec_hit;
  assign CMD_PSEC_IDX = s_r.cmd_psec_idx;
  assign OVL_ACTIVE = s_r.ovl;
  assign OVL_SECTOR = s_r.ovl_sector;
endmodule // flash_sector_map

// [testbench/fsmap_checker_properties.sv]
`timescale 1ns/1ps
// ----------
// Read path and command path checks
// ----------
module fsmap_checker #(
  parameter logic [7:0] MAX_SECTOR = 8'hFF,
  parameter logic [15:0] UNDEF_WORD = 16'hFFFF
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Watched ports
  input wire logic PARAM_EN,
  input wire logic ARRAY_RD,
  input wire logic [fsmap_pkg::DATA_W-1:0] ARRAY_RDATA,
  input wire logic TBL_RD,
  input wire logic [fsmap_pkg::TBL_W-1:0] TBL_IDX,
  input wire logic [fsmap_pkg::DATA_W-1:0] TBL_DATA,
  input wire logic RD_VALID,
  input wire logic [fsmap_pkg::DATA_W-1:0] RD_DATA,
  input wire logic CMD_VALID,
  input wire logic [fsmap_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [fsmap_pkg::SEC_W-1:0] CMD_SECTOR,
  input wire logic CMD_PSEC_HIT,
  input wire logic [2:0] CMD_PSEC_IDX,
  input wire logic OVL_ACTIVE
);
  import fsmap_pkg::*;
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  array_read_a: assert property (
    ARRAY_RD |=> RD_VALID && RD_DATA == $past(ARRAY_RDATA)) else $error("array answer wrong");
  sector_index_a: assert property (
    CMD_VALID |-> CMD_SECTOR == (CMD_ADDR[24:17] & MAX_SECTOR)) else $error("sector index wrong");
  psec_decode_a: assert property (
    CMD_VALID && CMD_PSEC_HIT |-> PARAM_EN && CMD_PSEC_IDX == CMD_ADDR[13:11] &&
    (CMD_SECTOR == 8'h00 ? CMD_ADDR[16:14] == 3'h0 :
     CMD_SECTOR == MAX_SECTOR && CMD_ADDR[16:14] == 3'h7)) else $error("param decode wrong");
  other_sector_a: assert property (
    OVL_ACTIVE && $past(OVL_ACTIVE) |-> !ARRAY_RD) else $error("array read while overlaid");
  table_range_a: assert property (
    TBL_RD |-> OVL_ACTIVE && !ARRAY_RD && TBL_IDX <= 7'h79) else $error("table strobe wrong");
  query_byte_a: assert property (
    TBL_RD && TBL_IDX >= 7'h10 |=> RD_VALID && RD_DATA == {8'h00, $past(TBL_DATA[7:0])})
    else $error("query word high byte set");
  ident_word_a: assert property (
    TBL_RD && TBL_IDX <= 7'h0F |=> RD_VALID && RD_DATA == $past(TBL_DATA))
    else $error("ident word wrong");
  overlay_cause_a: assert property (
    $changed(OVL_ACTIVE) |-> CMD_VALID) else $error("overlay changed without a write");
  undef_drive_a: assert property (
    RD_VALID && !$past(ARRAY_RD) && !$past(TBL_RD) |-> RD_DATA == UNDEF_WORD)
    else $error("undefined word wrong");
endmodule // fsmap_checker

bind flash_sector_map fsmap_checker #(.MAX_SECTOR(MAX_SECTOR), .UNDEF_WORD(UNDEF_WORD)) chk_u (
  .CLK_SYS(CLK_SYS), .RST(RST), .PARAM_EN(PARAM_EN), .ARRAY_RD(ARRAY_RD),
  .ARRAY_RDATA(ARRAY_RDATA), .TBL_RD(TBL_RD), .TBL_IDX(TBL_IDX), .TBL_DATA(TBL_DATA),
  .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .CMD_VALID(CMD_VALID), .CMD_ADDR(CMD_ADDR),
  .CMD_SECTOR(CMD_SECTOR), .CMD_PSEC_HIT(CMD_PSEC_HIT), .CMD_PSEC_IDX(CMD_PSEC_IDX),
  .OVL_ACTIVE(OVL_ACTIVE));

// [testbench/host_link_model.sv]
`timescale 1ns/1ps
// ----------
// Host controller: one word per frame, clock runs only inside frames
// ----------
module host_link_model (
  // Link lines
  output logic ck,
  output logic cs_n,
  output logic wr,
  output logic [fsmap_pkg::ADDR_W-1:0] addr,
  output logic [fsmap_pkg::DATA_W-1:0] wdata
);
  import fsmap_pkg::*;
  // Idle: clock low, deselected
  initial begin
    ck = 1'b0;
    cs_n = 1'b1;
    wr = 1'b0;
    addr = '0;
    wdata = '0;
  end
  // Lines held from select to deselect; 40 ns setup covers the sync delay
  task automatic xfer(input logic w, input logic [24:0] a, input logic [15:0] d);
    #2;
    wr = w;
    addr = a;
    wdata = d;
    cs_n = 1'b0;
    #40 ck = 1'b1;
    #40 ck = 1'b0;
    #40 cs_n = 1'b1;
    // Released lines must not keep the old value
    wr = ~w;
    addr = ~a;
    wdata = ~d;
    #40;
  endtask
endmodule // host_link_model

// [testbench/tb_flash_sector_map.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_flash_sector_map;
  import fsmap_pkg::*;
  // ----------
  // Bench state and models
  // ----------
  localparam logic [7:0] MAXS = 8'h7F; // Middle density
  localparam logic [16:0] OFFS [6] = '{17'h0, 17'hF, 17'h10, 17'h79, 17'h7A, 17'h1FFFF};
  localparam logic [16:0] CORN [4] = '{17'h03FFF, 17'h04000, 17'h1BFFF, 17'h1C000};
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic PARAM_EN = 1'b0;
  logic PARAM_TOP = 1'b0;
  logic ovl = 1'b0;
  logic LINK_CK, LINK_CS_N, LINK_WR, ARRAY_RD, TBL_RD, RD_VALID, CMD_VALID, CMD_PSEC_HIT;
  logic OVL_ACTIVE;
  logic [ADDR_W-1:0] LINK_ADDR, ARRAY_ADDR, CMD_ADDR, a;
  logic [DATA_W-1:0] LINK_WDATA, ARRAY_RDATA, TBL_DATA, RD_DATA, CMD_DATA, lo;
  logic [TBL_W-1:0] TBL_IDX;
  logic [SEC_W-1:0] CMD_SECTOR, OVL_SECTOR, osec, sec;
  logic [2:0] CMD_PSEC_IDX;
  logic [15:0] seed = 16'h765E;
  int num_errors = 0, comparisons = 0, rd_cnt = 0, cmd_cnt = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  host_link_model host_u (.ck(LINK_CK), .cs_n(LINK_CS_N), .wr(LINK_WR), .addr(LINK_ADDR),
    .wdata(LINK_WDATA));
  flash_sector_map #(.MAX_SECTOR(MAXS)) dut_u (.CLK_SYS(CLK_SYS), .RST(RST),
    .LINK_CK(LINK_CK), .LINK_CS_N(LINK_CS_N), .LINK_WR(LINK_WR), .LINK_ADDR(LINK_ADDR),
    .LINK_WDATA(LINK_WDATA), .PARAM_EN(PARAM_EN), .PARAM_TOP(PARAM_TOP),
    .ARRAY_RD(ARRAY_RD), .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_RDATA(ARRAY_RDATA),
    .TBL_RD(TBL_RD), .TBL_IDX(TBL_IDX), .TBL_DATA(TBL_DATA), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA), .CMD_VALID(CMD_VALID), .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA),
    .CMD_SECTOR(CMD_SECTOR), .CMD_PSEC_HIT(CMD_PSEC_HIT), .CMD_PSEC_IDX(CMD_PSEC_IDX),
    .OVL_ACTIVE(OVL_ACTIVE), .OVL_SECTOR(OVL_SECTOR));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] arr_word(input logic [24:0] x);
    return x[15:0] ^ {x[24:17], 8'h5A};
  endfunction
  // Table words have a busy high byte so zeroing shows
  function automatic logic [15:0] tbl_word(input logic [6:0] i);
    return {1'b1, i, 1'b0, ~i};
  endfunction
  assign ARRAY_RDATA = arr_word(ARRAY_ADDR);
  assign TBL_DATA = tbl_word(TBL_IDX);
  function automatic logic [15:0] exp_rd(input logic [24:0] x);
    if (!ovl) return arr_word(x);
    if (x[24:17] != osec || x[16:0] > 17'h79) return UNDEF_WORD_DEF;
    if (x[16:0] > 17'hF) return tbl_word(x[6:0]) & 16'h00FF;
    return tbl_word(x[6:0]);
  endfunction
  function automatic logic psec(input logic [24:0] x);
    return PARAM_EN && (PARAM_TOP ? x[24:17] == MAXS && x[16:14] == 3'h7 :
      x[24:17] == 8'h00 && x[16:14] == 3'h0);
  endfunction
  // Answers counted mid-cycle, clear of the edge
  always @(negedge CLK_SYS) begin
    rd_cnt += int'(RD_VALID === 1'b1);
    cmd_cnt += int'(CMD_VALID === 1'b1);
  end
  task automatic print_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One frame, then the answer compared against the model
  task automatic xact(input logic w, input logic [24:0] x, input logic [15:0] d);
    int n0;
    n0 = w ? cmd_cnt : rd_cnt;
    @(posedge CLK_SYS);
    host_u.xfer(w, x, d);
    for (int i = 0; i < 20 && n0 == (w ? cmd_cnt : rd_cnt); i++) @(posedge CLK_SYS);
    // A lost answer ends the run here, so nothing is compared after it
    if (n0 == (w ? cmd_cnt : rd_cnt)) begin
      num_errors++;
      $display("CHECK FAILED t=%0t no answer", $time);
      print_verdict();
    end else if (w) begin
      `CHK(CMD_ADDR, x)
      `CHK(CMD_DATA, d)
      `CHK(CMD_SECTOR, x[24:17])
      `CHK(CMD_PSEC_HIT, psec(x))
      `CHK(CMD_PSEC_IDX, x[13:11])
      `CHK(OVL_ACTIVE, ovl)
      if (ovl) `CHK(OVL_SECTOR, osec)
    end else begin
      `CHK(RD_DATA, exp_rd(x))
      // Storage addresses hold until the next read of their kind
      if (!ovl) `CHK(ARRAY_ADDR, x)
      if (ovl && x[24:17] == osec) `CHK(TBL_IDX, x[6:0])
    end
  endtask
  // ----------
  // Scenarios
  // ----------
  initial begin
    repeat (8) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    // Each placement: edges of the small sectors, then random traffic
    for (int m = 0; m < 3; m++) begin
      PARAM_EN <= (m != 0);
      PARAM_TOP <= (m == 2);
      for (int j = 0; j < 4; j++) xact(1'b1, {j < 2 ? 8'h00 : MAXS, CORN[j]}, 16'h1231);
      for (int j = 0; j < 10; j++) begin
        seed = lfsr(seed);
        lo = seed;
        seed = lfsr(seed);
        sec = seed[1:0] == 2'h0 ? 8'h00 : seed[1:0] == 2'h1 ? MAXS : {1'b0, seed[15:9]};
        a = {sec, seed[8], lo};
        xact(1'b1, a, {seed[15:4], 4'h1});
        xact(1'b0, a, 16'h0000);
      end
    end
    // Both entry kinds give one overlay; writes leave the tables alone
    for (int k = 0; k < 2; k++) begin
      sec = k ? 8'h05 : 8'h2A;
      if (k == 0) xact(1'b1, {sec, 17'h555}, 16'h00AA);
      if (k == 0) xact(1'b1, {sec, 17'h2AA}, 16'h0055);
      ovl = 1'b1;
      osec = sec;
      xact(1'b1, {sec, k ? 17'h055 : 17'h555}, k ? 16'h0098 : 16'h0090);
      foreach (OFFS[i]) xact(1'b0, {sec, OFFS[i]}, 16'h0000);
      xact(1'b0, {sec + 8'h01, 17'h00003}, 16'h0000);
      xact(1'b1, {sec, 17'h00001}, 16'hAB01);
      xact(1'b0, {sec, 17'h00001}, 16'h0000);
      ovl = 1'b0;
      xact(1'b1, {sec, 17'h00000}, 16'h00F0);
      xact(1'b0, {sec, 17'h00001}, 16'h0000);
    end
    // Broken unlock must not enter the overlay
    xact(1'b1, {8'h11, 17'h555}, 16'h00AA);
    xact(1'b1, {8'h11, 17'h2AA}, 16'h0011);
    xact(1'b1, {8'h11, 17'h555}, 16'h0090);
    print_verdict();
  end
endmodule // tb_flash_sector_map
